// file: ao_chan_map.svh
// Purpose: Offsets-free constant map for the analog output value path
// Assumes: 250 MHz core clock, four channels
// Notes:   Limits are digital input spans per range and resolution
`ifndef AO_CHAN_MAP_SVH
`define AO_CHAN_MAP_SVH

// Channel count and conversion slot length in clocks
`define AO_CH_NUM 4
`define AO_CONV_CYCLES 8

// Digital input limits, 14-bit variant
`define AO_B14_MIN (-64'sh2000)
`define AO_B14_MAX 64'sh1FFF
`define AO_U14_MAX 64'sh3FFF

// Digital input limits, 16-bit variant
`define AO_B16_MIN (-64'sh6978)
`define AO_B16_MAX 64'sh6978
`define AO_U16_MAX 64'sh6978

// Calibration gain divisor
`define AO_GAIN_DIV 64'shFFFF

// Slew time base and clock rate
`define AO_SLEW_BASE_MS 100
`define AO_CLK_MHZ 250

// Slew rates in steps per time base
`define AO_RATE_64 32'h40
`define AO_RATE_125 32'h7D
`define AO_RATE_250 32'hFA
`define AO_RATE_500 32'h1F4
`define AO_RATE_1000 32'h3E8

// Reset values of settings
`define AO_SLEW_SEL_FASTEST 4'hE

`endif

// file: ao_chan_path.sv
// Purpose: Four-channel analog output value path and conversion sequencer
// Assumes: Settings arrive as steady ports from the controller side
// Notes:   One shared datapath serves the channel in the current slot
//
// Operation
// - Seven ranges; unset range means zero-to-ten volts
// - 14-bit: bipolar -8192..8191, unipolar 0..16383
// - 16-bit: bipolar and unipolar limits of 27000
// - Scaling maps user span onto range span
// - Scaling clamps user value to its limits first
// - Closed channel outputs zero; run outputs converted
// - Hold clear mode drives offset value on stop
// - Offset value is output for input zero
// - Hold mode keeps last output value on stop
// - User mode drives user value, default range max
// - Hold off and clear mode by default
// - Slew control limits output movement speed
// - Slew off applies new value at once
// - Fifteen slew rates, fastest by default
// - Data offset shifts data when enabled
// - Offset sum clamps to range digital limits
// - Converter word is data times gain/65535 plus offset
// - Sequencer skips closed channels
`timescale 1ns/1ps
`include "ao_chan_map.svh"

module ao_chan_path #(
    parameter int SLEW_BASE_CYCLES = `AO_SLEW_BASE_MS * 1000 * `AO_CLK_MHZ
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Module settings
    input wire logic hi_res_in,
    input wire ao_chan_pkg::cpu_state_e cpu_state_in,
    input wire ao_chan_pkg::chan_cfg_s cfg_in [`AO_CH_NUM],
    // Controller output words
    input wire logic signed [31:0] data_in [`AO_CH_NUM],
    // Converter side
    output logic load_out,
    output logic [1:0] load_chan_out,
    output logic signed [31:0] load_code_out,
    output logic signed [31:0] chan_code_out [`AO_CH_NUM],
    output logic signed [31:0] chan_data_out [`AO_CH_NUM]
);

    localparam logic [7:0] CNT_LAST = 8'(`AO_CONV_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic signed [63:0] clamp64(input logic signed [63:0] v,
            input logic signed [63:0] lo, input logic signed [63:0] hi);
        clamp64 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Next open channel after cur, cur itself last
    function automatic logic [1:0] next_open(input logic [1:0] cur,
            input logic [3:0] open);
        logic [1:0] n;
        logic found;
        n = cur;
        found = 1'b0;
        for (int i = 1; i <= 4; i++) begin
            if (!found && open[2'(cur + 2'(i))]) begin
                n = 2'(cur + 2'(i));
                found = 1'b1;
            end
        end
        next_open = n;
    endfunction

    // Rate table: four fixed entries, then doubling from 1000
    function automatic logic [31:0] slew_rate(input logic [3:0] sel);
        unique case (sel)
            4'h0: slew_rate = `AO_RATE_64;
            4'h1: slew_rate = `AO_RATE_125;
            4'h2: slew_rate = `AO_RATE_250;
            4'h3: slew_rate = `AO_RATE_500;
            4'hF: slew_rate = `AO_RATE_1000 << 10; // Out-of-table code runs fastest
            default: slew_rate = `AO_RATE_1000 << (sel - 4'h4);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    ao_chan_pkg::seq_state_e state_r, state_nxt;
    logic [1:0] sel_r, sel_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [3:0] open_w;
    logic [2:0] nopen;
    logic commit;

    // Open channel vector and count
    always_comb begin
        nopen = 3'h0;
        for (int i = 0; i < `AO_CH_NUM; i++) begin
            open_w[i] = cfg_in[i].open;
            nopen = nopen + 3'(cfg_in[i].open);
        end
    end

    // Closed channels never take a slot
    always_comb begin
        state_nxt = state_r;
        sel_nxt = sel_r;
        cnt_nxt = cnt_r;
        commit = 1'b0;
        unique case (state_r)
            ao_chan_pkg::ST_IDLE: begin
                if (|open_w) begin
                    state_nxt = ao_chan_pkg::ST_CONV;
                    sel_nxt = next_open(sel_r, open_w);
                    cnt_nxt = 8'h00;
                end
            end
            ao_chan_pkg::ST_CONV: begin
                if (!open_w[sel_r]) begin
                    cnt_nxt = 8'h00; // Slot abandoned when closed mid-way
                    sel_nxt = next_open(sel_r, open_w);
                    if (!(|open_w)) begin
                        state_nxt = ao_chan_pkg::ST_IDLE;
                    end
                end else if (cnt_r == CNT_LAST) begin
                    commit = 1'b1;
                    cnt_nxt = 8'h00;
                    sel_nxt = next_open(sel_r, open_w);
                end else begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            default: begin
                state_nxt = ao_chan_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= ao_chan_pkg::ST_IDLE;
            sel_r <= 2'h0;
            cnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            sel_r <= sel_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared datapath for the channel in the slot

    ao_chan_pkg::chan_cfg_s c;
    logic signed [31:0] cur_r [`AO_CH_NUM];
    logic signed [31:0] code_r [`AO_CH_NUM];
    logic signed [31:0] cur_nxt [`AO_CH_NUM];
    logic signed [31:0] code_nxt [`AO_CH_NUM];
    logic signed [63:0] lim_lo, lim_hi, xs, scaled, d_run, d_clear, d_user;
    logic signed [63:0] target, prod, cal;
    logic signed [31:0] target32, slew_val, cur_sel;
    logic [63:0] step_raw;
    logic [31:0] step;
    logic stopped;

    // Range limits; bipolar ranges are centred on zero
    always_comb begin
        c = cfg_in[sel_r];
        cur_sel = cur_r[sel_r];
        stopped = (cpu_state_in != ao_chan_pkg::CPU_RUN);
        if (c.range == ao_chan_pkg::RNG_BIP10 || c.range == ao_chan_pkg::RNG_BIP5) begin
            lim_lo = hi_res_in ? `AO_B16_MIN : `AO_B14_MIN;
            lim_hi = hi_res_in ? `AO_B16_MAX : `AO_B14_MAX;
        end else begin
            lim_lo = 64'sh0;
            lim_hi = hi_res_in ? `AO_U16_MAX : `AO_U14_MAX;
        end
    end

    // Scale, offset, then stop selection, in that order
    always_comb begin
        xs = 64'(data_in[sel_r]);
        scaled = xs;
        if (c.scale_en) begin
            xs = clamp64(xs, 64'(c.scale_lo), 64'(c.scale_hi));
            scaled = lim_lo + ((xs - 64'(c.scale_lo)) * (lim_hi - lim_lo))
                / (64'(c.scale_hi) - 64'(c.scale_lo));
        end
        d_run = clamp64(scaled + (c.ofs_en ? 64'(c.ofs) : 64'sh0),
            lim_lo, lim_hi);
        d_clear = clamp64(c.ofs_en ? 64'(c.ofs) : 64'sh0, lim_lo, lim_hi);
        d_user = c.user_set ? clamp64(64'(c.user_val), lim_lo, lim_hi) : lim_hi;
        target = d_run;
        if (stopped && c.hold_en) begin
            unique case (c.hold_mode)
                ao_chan_pkg::HOLD_KEEP: target = 64'(cur_sel);
                ao_chan_pkg::HOLD_USER: target = d_user;
                default: target = d_clear;
            endcase
        end
        target32 = 32'(target);
    end

    // Per-update share of the rate: one slot per open channel per visit
    always_comb begin
        step_raw = (64'(slew_rate(c.slew_sel)) * 64'(`AO_CONV_CYCLES) * 64'(nopen))
            / 64'(SLEW_BASE_CYCLES);
        step = (step_raw == 64'h0) ? 32'h1 : 32'(step_raw);
    end

    ao_slew_step u_slew (
        .slew_en_in(c.slew_en),
        .step_in(step),
        .target_in(target32),
        .current_in(cur_sel),
        .next_out(slew_val)
    );

    // Calibration ahead of the converter
    always_comb begin
        prod = 64'(slew_val) * 64'(c.gain);
        cal = prod / `AO_GAIN_DIV + 64'(c.cal_ofs);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel value and code registers

    for (genvar g = 0; g < `AO_CH_NUM; g++) begin : g_ch
        // Closed channels are forced to zero every clock
        always_comb begin
            cur_nxt[g] = cur_r[g];
            code_nxt[g] = code_r[g];
            if (!open_w[g]) begin
                cur_nxt[g] = 32'sh0;
                code_nxt[g] = 32'sh0;
            end else if (commit && sel_r == 2'(g)) begin
                cur_nxt[g] = slew_val;
                code_nxt[g] = 32'(cal);
            end
        end

        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                cur_r[g] <= 32'sh0;
                code_r[g] <= 32'sh0;
            end else begin
                cur_r[g] <= cur_nxt[g];
                code_r[g] <= code_nxt[g];
            end
        end

        assign chan_code_out[g] = code_r[g];
        assign chan_data_out[g] = cur_r[g];
    end

    // Converter load strobe follows each committed slot
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            load_out <= 1'b0;
            load_chan_out <= 2'h0;
            load_code_out <= 32'sh0;
        end else begin
            load_out <= commit;
            load_chan_out <= commit ? sel_r : load_chan_out;
            load_code_out <= commit ? 32'(cal) : load_code_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    // Load strobe naming the given channel
    sequence s_load_of(logic [1:0] ch);
        (load_out && load_chan_out == ch);
    endsequence

    // No further commit inside one conversion slot
    sequence s_slot_quiet;
        (!commit)[*7];
    endsequence

    property p_closed_zero;
        !open_w[0] |=> (chan_code_out[0] == 32'sh0 && chan_data_out[0] == 32'sh0);
    endproperty
    a_closed_zero: assert property (p_closed_zero)
        else $error("closed channel not zero");

    property p_load_open;
        commit |-> open_w[sel_r] ##1 s_load_of($past(sel_r));
    endproperty
    a_load_open: assert property (p_load_open)
        else $error("load missing or for closed channel");

    property p_slot_len;
        commit |=> load_out ##0 s_slot_quiet;
    endproperty
    a_slot_len: assert property (p_slot_len)
        else $error("slots closer than conversion time");

    property p_clear;
        commit && stopped && c.hold_en && c.hold_mode == ao_chan_pkg::HOLD_CLEAR
            && !c.slew_en |=> chan_data_out[$past(sel_r)] == 32'($past(d_clear));
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear mode did not drive offset value");

    property p_keep;
        commit && stopped && c.hold_en && c.hold_mode == ao_chan_pkg::HOLD_KEEP
            |=> chan_data_out[$past(sel_r)] == $past(cur_sel);
    endproperty
    a_keep: assert property (p_keep)
        else $error("hold mode changed output");

    property p_no_slew;
        commit && !c.slew_en |=> chan_data_out[$past(sel_r)] == $past(target32);
    endproperty
    a_no_slew: assert property (p_no_slew)
        else $error("value not applied at once");

    property p_slew_bound;
        commit && c.slew_en |=> ($past(target32) >= $past(cur_sel)
            ? (chan_data_out[$past(sel_r)] - $past(cur_sel)) <= $signed($past(step))
            : ($past(cur_sel) - chan_data_out[$past(sel_r)]) <= $signed($past(step)));
    endproperty
    a_slew_bound: assert property (p_slew_bound)
        else $error("slew step exceeded");

    property p_in_range;
        commit |=> 64'(chan_data_out[$past(sel_r)]) >= $past(lim_lo)
            && 64'(chan_data_out[$past(sel_r)]) <= $past(lim_hi);
    endproperty
    a_in_range: assert property (p_in_range)
        else $error("value outside range limits");

endmodule

// file: ao_chan_pkg.sv
// Purpose: Types shared by the analog output value path
// Assumes: Constants live in ao_chan_map.svh
// Notes:   Range code 0 is the zero-to-ten-volt range
package ao_chan_pkg;

    // Output ranges; bipolar ones are BIP10 and BIP5
    typedef enum logic [2:0] {
        RNG_V0_10 = 3'h0,
        RNG_BIP10 = 3'h1,
        RNG_BIP5 = 3'h2,
        RNG_V0_5 = 3'h3,
        RNG_V1_5 = 3'h4,
        RNG_I0_20 = 3'h5,
        RNG_I4_20 = 3'h6
    } range_e;

    // Output hold modes
    typedef enum logic [1:0] {
        HOLD_CLEAR = 2'h0,
        HOLD_KEEP = 2'h1,
        HOLD_USER = 2'h2
    } hold_mode_e;

    // Controller state
    typedef enum logic [1:0] {
        CPU_RUN = 2'h0,
        CPU_STOP = 2'h1,
        CPU_STOP_ERR = 2'h2
    } cpu_state_e;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } seq_state_e;

    // Per-channel configuration
    typedef struct packed {
        logic open;
        range_e range;
        logic scale_en;
        logic signed [31:0] scale_lo;
        logic signed [31:0] scale_hi;
        logic ofs_en;
        logic signed [16:0] ofs;
        logic hold_en;
        hold_mode_e hold_mode;
        logic user_set;
        logic signed [16:0] user_val;
        logic slew_en;
        logic [3:0] slew_sel;
        logic signed [17:0] gain;
        logic signed [16:0] cal_ofs;
    } chan_cfg_s;

endpackage

// file: ao_cpu_model.sv
// Purpose: Controller-side model that drives channel settings and words
// Assumes: Called by the bench just after a rising clock edge
// Notes:   Host-illegal settings are clipped or fixed before they are sent
`timescale 1ns/1ps
`include "ao_chan_map.svh"

module ao_cpu_model (
    // Settings and output words
    output logic hi_res_out,
    output ao_chan_pkg::cpu_state_e cpu_state_out,
    output ao_chan_pkg::chan_cfg_s cfg_out [`AO_CH_NUM],
    output logic signed [31:0] data_out [`AO_CH_NUM]
);
    ////////////////////////////////////////
    // Power-on settings, unit calibration
    task automatic init(input int ch, input logic open);
        cfg_out[ch] = '0;
        cfg_out[ch].open = open;
        cfg_out[ch].slew_sel = `AO_SLEW_SEL_FASTEST;
        cfg_out[ch].gain = 18'sh0FFFF;
        data_out[ch] = 32'sh0;
    endtask

    // Range, scaling, offset and word; limits fixed so upper stays above lower
    task automatic setup(input int ch, input logic res, input int rng, input logic sc,
            input int ofs, input int word);
        int lim;
        lim = res ? 32'sh0FA00 : 32'sh3FFF;
        hi_res_out = res;
        cfg_out[ch].open = 1'b1;
        cfg_out[ch].range = ao_chan_pkg::range_e'(rng[2:0]);
        cfg_out[ch].scale_en = sc;
        cfg_out[ch].scale_lo = 32'sh3E8;
        cfg_out[ch].scale_hi = 32'sh1770;
        cfg_out[ch].ofs_en = (ofs != 0);
        cfg_out[ch].ofs = 17'(ofs > lim ? lim : (ofs < -lim ? -lim : ofs));
        data_out[ch] = word;
    endtask

    // Output hold settings and controller state
    task automatic hold(input int ch, input logic en, input int mode, input logic uset,
            input int st, input int word);
        cfg_out[ch].hold_en = en;
        cfg_out[ch].hold_mode = ao_chan_pkg::hold_mode_e'(mode[1:0]);
        cfg_out[ch].user_set = uset;
        cfg_out[ch].user_val = 17'sh309;
        cpu_state_out = ao_chan_pkg::cpu_state_e'(st[1:0]);
        data_out[ch] = word;
    endtask

    // Slew control and word
    task automatic slew(input int ch, input logic en, input int sel, input int word);
        cfg_out[ch].slew_en = en;
        cfg_out[ch].slew_sel = sel[3:0];
        data_out[ch] = word;
    endtask

    // Calibration gain and offset
    task automatic cal(input int ch, input int g, input int c);
        cfg_out[ch].gain = 18'(g);
        cfg_out[ch].cal_ofs = 17'(c);
    endtask

    // All channels closed at power-on
    initial begin
        hi_res_out = 1'b0;
        cpu_state_out = ao_chan_pkg::CPU_RUN;
        for (int i = 0; i < `AO_CH_NUM; i++) begin
            init(i, 1'b0);
        end
    end
endmodule

// file: ao_slew_step.sv
// Purpose: One slew-limited move of a channel value toward its target
// Assumes: Step is at least one; values fit in 32 signed bits
// Notes:   Purely combinational, shared by all channels
`timescale 1ns/1ps

module ao_slew_step (
    // Control
    input wire logic slew_en_in,
    input wire logic [31:0] step_in,
    // Values
    input wire logic signed [31:0] target_in,
    input wire logic signed [31:0] current_in,
    output logic signed [31:0] next_out
);

    logic signed [33:0] diff;
    logic signed [33:0] step_s;

    // Move by at most one share, never past the target
    always_comb begin
        diff = 34'(target_in) - 34'(current_in);
        step_s = $signed({2'h0, step_in});
        if (!slew_en_in) begin
            next_out = target_in;
        end else if (diff > step_s) begin
            next_out = 32'(34'(current_in) + step_s);
        end else if (diff < -step_s) begin
            next_out = 32'(34'(current_in) - step_s);
        end else begin
            next_out = target_in;
        end
    end

endmodule

// file: tb_top.sv
// Purpose: Self-checking bench for the analog output value path
// Assumes: One open channel unless a test says otherwise
// Notes:   Settings change right after a load, so the next load sees them
`timescale 1ns/1ps
`include "ao_chan_map.svh"

module tb_top;
    // Short slew time base keeps the run brief
    localparam int BASE = 1000;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic hi_res;
    ao_chan_pkg::cpu_state_e cpu_state;
    ao_chan_pkg::chan_cfg_s cfg [`AO_CH_NUM];
    logic signed [31:0] data [`AO_CH_NUM];
    logic load_out;
    logic [1:0] load_chan_out;
    logic signed [31:0] load_code_out;
    logic signed [31:0] chan_code_out [`AO_CH_NUM];
    logic signed [31:0] chan_data_out [`AO_CH_NUM];
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    int waited;
    longint gain_v = 65535;
    longint cal_v = 0;
    longint share;
    int rates [4] = '{64, 125, 250, 500};
    int order [4] = '{2, 0, 2, 0};
    // Rows: 16-bit, range, scaling, offset, word, expected data
    int rows [19][6] = '{
        '{0, 0, 0, 0, -5, 0}, '{0, 1, 0, 0, -9000, -8192}, '{0, 2, 0, 0, 9000, 8191},
        '{0, 3, 0, 0, 20000, 16383}, '{0, 4, 0, 0, 100, 100}, '{0, 5, 0, 0, -1, 0},
        '{0, 6, 0, 0, 16383, 16383}, '{1, 1, 0, 0, -30000, -27000},
        '{1, 2, 0, 0, 27000, 27000}, '{1, 0, 0, 0, 30000, 27000},
        '{1, 5, 0, 0, 26999, 26999}, '{1, 0, 1, 0, 2000, 5400}, '{1, 0, 1, 0, 500, 0},
        '{1, 0, 1, 0, 7000, 27000}, '{1, 1, 1, 0, 3500, 0}, '{1, 0, 1, 50, 2000, 5450},
        '{1, 0, 0, 50, -50, 0}, '{1, 0, 0, 50, 26990, 27000}, '{0, 0, 0, -50, 30, 0}};
    // Rows: hold on, mode, user set, state, word, expected data
    int hrows [10][6] = '{
        '{0, 0, 0, 0, 1234, 1334}, '{0, 0, 0, 1, 1234, 1334}, '{1, 0, 0, 1, 1234, 100},
        '{1, 0, 0, 2, 1234, 100}, '{1, 1, 0, 0, 1234, 1334}, '{1, 1, 0, 1, 5000, 1334},
        '{1, 1, 0, 2, 5000, 1334}, '{1, 2, 0, 1, 5000, 16383},
        '{1, 2, 1, 0, 5000, 5100}, '{1, 2, 1, 2, 5000, 777}};

    ao_cpu_model u_ao_cpu_model (
        .hi_res_out(hi_res),
        .cpu_state_out(cpu_state),
        .cfg_out(cfg),
        .data_out(data)
    );

    ao_chan_path #(.SLEW_BASE_CYCLES(BASE)) u_ao_chan_path (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .hi_res_in(hi_res),
        .cpu_state_in(cpu_state),
        .cfg_in(cfg),
        .data_in(data),
        .load_out(load_out),
        .load_chan_out(load_chan_out),
        .load_code_out(load_code_out),
        .chan_code_out(chan_code_out),
        .chan_data_out(chan_data_out)
    );

    ////////////////////////////////////////
    // 250 MHz clock
    always #2 clk_in = ~clk_in;

    // Hang guard, well above the expected run length
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic cmp(input string what, input longint exp, input logic signed [31:0] got);
        checks++;
        if (got !== 32'(exp)) begin
            num_errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Next load of a channel (any if negative); waited holds the edge count
    task automatic wait_load(input int ch);
        waited = 0;
        do begin
            tick(1);
            waited++;
        end while (!(load_out === 1'b1 && (ch < 0 || load_chan_out === 2'(ch)))
            && waited < 100);
        if (!(load_out === 1'b1 && (ch < 0 || load_chan_out === 2'(ch)))) begin
            cmp("load_seen", 1, 0);
        end
    endtask

    // Data word and calibrated code of the next load
    task automatic chk(input int ch, input longint exp);
        wait_load(ch);
        cmp("chan_data", exp, chan_data_out[ch]);
        cmp("chan_code", exp * gain_v / 65535 + cal_v, chan_code_out[ch]);
        cmp("load_code", exp * gain_v / 65535 + cal_v, load_code_out);
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial begin
        tick(2);
        cmp("reset_code", 0, load_code_out);
        cmp("reset_data", 0, chan_data_out[0]);
        tick(1);
        rstn_in = 1'b1;
        // Every channel closed: no conversion at all
        repeat (20) begin
            tick(1);
            cmp("idle_load", 0, {31'h0, load_out});
        end
        // Default range, first slot timing, slot spacing
        u_ao_cpu_model.init(0, 1'b1);
        u_ao_cpu_model.slew(0, 1'b0, 14, 20000);
        wait_load(0);
        cmp("first_gap", 9, waited);
        chk(0, 16383);
        cmp("slot_gap", 8, waited);
        // Ranges, limits, scaling and offset in turn
        foreach (rows[i]) begin
            wait_load(0);
            u_ao_cpu_model.setup(0, rows[i][0] != 0, rows[i][1], rows[i][2] != 0,
                rows[i][3], rows[i][4]);
            chk(0, rows[i][5]);
        end
        // Calibration on a negative and a positive word
        wait_load(0);
        u_ao_cpu_model.cal(0, 32767, -100);
        gain_v = 32767;
        cal_v = -100;
        u_ao_cpu_model.setup(0, 1'b0, 1, 1'b0, 0, -8192);
        chk(0, -8192);
        u_ao_cpu_model.setup(0, 1'b0, 0, 1'b0, 0, 16383);
        chk(0, 16383);
        u_ao_cpu_model.cal(0, 65535, 0);
        gain_v = 65535;
        cal_v = 0;
        // Output hold modes across run, stop and stop on error
        u_ao_cpu_model.setup(0, 1'b0, 0, 1'b0, 100, 0);
        foreach (hrows[i]) begin
            wait_load(0);
            u_ao_cpu_model.hold(0, hrows[i][0] != 0, hrows[i][1], hrows[i][2] != 0,
                hrows[i][3], hrows[i][4]);
            chk(0, hrows[i][5]);
        end
        // Closing while stopped forces zero
        u_ao_cpu_model.init(0, 1'b0);
        tick(1);
        cmp("closed_data", 0, chan_data_out[0]);
        cmp("closed_code", 0, chan_code_out[0]);
        // Round robin over two open channels
        u_ao_cpu_model.init(0, 1'b1);
        u_ao_cpu_model.init(2, 1'b1);
        u_ao_cpu_model.hold(0, 1'b0, 0, 1'b0, 0, 0);
        u_ao_cpu_model.slew(2, 1'b0, 14, 77);
        wait_load(0);
        foreach (order[i]) begin
            wait_load(-1);
            cmp("load_chan", order[i], {30'h0, load_chan_out});
            cmp("load_gap", 8, waited);
        end
        cmp("chan2_data", 77, chan_data_out[2]);
        u_ao_cpu_model.init(2, 1'b0);
        // Every slew rate and the spare code: one limited step, slew off jumps back
        for (int k = 0; k < 16; k++) begin
            share = k < 4 ? rates[k] : 1000 << (k == 15 ? 10 : k - 4);
            share = share * 8 / BASE;
            if (share < 1) share = 1;
            wait_load(0);
            u_ao_cpu_model.slew(0, 1'b0, k, 0);
            chk(0, 0);
            u_ao_cpu_model.slew(0, 1'b1, k, 16383);
            chk(0, share);
        end
        chk(0, 16383);
        results();
    end
endmodule
